// file: design/ofs_supervisor.sv
// Output fault supervisor: open-load filter and latch, supply shutdown, response words
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: An output is checked for open load only while it is commanded off, by its own comparator.
// R2: Every pull-down current source is enabled from power-up.
// R3: An output whose pull-down is disabled always reports open-load status 0.
// R4: Pull-downs turn off only in sleep or by explicit serial command.
// R5: Open-load detection is filtered by a fault delay of 100 to 450 us.
// R6: Each chip-select rising edge restarts the delay; the comparator counts only after expiry.
// R7: A cleared open load leaves the fault latched in the response until the host reads it.
// R8: Logic-supply undervoltage switches all outputs off and resets all control registers.
// R9: Battery undervoltage likewise switches all outputs off and resets all control registers.
// R10: Between battery undervoltage and 9 V commands still execute; status may be invalid.
// R11: Battery overvoltage holds all outputs off until the supply is normal again.
// R12: Status bits read 1 on fault; the leading bit flags overvoltage or thermal limit.
// R13: The second response message carries a trim bit, 0 untrimmed and 1 trimmed.
// R14: A thermal-limit query returns per-driver flags for driver one and the eight switches.
// R15: A latched fault clears once its response word is shifted out and the fault is gone.
module ofs_supervisor #(
    parameter int unsigned N_OUT     = ofs_pkg::N_OUT,
    parameter int unsigned DELAY_CYC = ofs_pkg::FILTER_CYC
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             sclk_i,
    input  wire logic             cs_n_i,
    input  wire logic             mosi_i,
    output logic                  miso_o,
    output logic                  miso_oe_n_o,
    input  wire logic [N_OUT-1:0] open_cmp_i,
    input  wire logic [N_OUT:0]   thermal_limit_flag_i,
    input  wire logic             logic_uv_i,
    input  wire logic             battery_supply_uv_i,
    input  wire logic             overvoltage_flag_i,
    input  wire logic             sleep_i,
    input  wire logic             trim_set_i,
    output logic [N_OUT-1:0]      octal_switch_output_o,
    output logic [N_OUT-1:0]      pulldown_en_o
);
    localparam int unsigned WB = ofs_pkg::WORD_BITS;

    typedef struct packed {
        logic [N_OUT-1:0] cmp_s1, cmp_s2;
        logic [N_OUT:0]   tl_s1, tl_s2;
        logic             uv_s1, uv_s2;
        logic             ov_s1, ov_s2;
        logic             slp_s1, slp_s2;
        logic [N_OUT-1:0] out_on;
        logic [N_OUT-1:0] pd_en;
        logic [N_OUT-1:0] ol_lat;
        logic [N_OUT-1:0] drv;
        logic [N_OUT-1:0] pd_eff;
        logic             rst_flag;
        ofs_pkg::ofs_msg_t msg;
    } ofs_core_t;

    ofs_core_t st_r;
    ofs_core_t st_nxt;

    ofs_link_if lk ();

    logic                            expired;
    logic [N_OUT-1:0]                pd_now;
    logic [N_OUT-1:0]                detect;
    logic [N_OUT-1:0]                clr_mask;
    logic [N_OUT-1:0]                report;
    logic                            good_frame;
    logic                            fault_lead;
    logic [ofs_pkg::CMD_W-1:0]       cmd;
    logic [WB-1:0]                   tx_w;

    ofs_spi_link u_link (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .sclk_i      (sclk_i),
        .cs_n_i      (cs_n_i),
        .mosi_i      (mosi_i),
        .miso_o      (miso_o),
        .miso_oe_n_o (miso_oe_n_o),
        .lk          (lk.link)
    );

    ofs_fault_timer #(
        .DELAY_CYC (DELAY_CYC)
    ) u_timer (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .restart_i (lk.frame_done), // see R6
        .expired_o (expired)
    );

    always_comb begin
        st_nxt        = st_r;
        st_nxt.cmp_s1 = open_cmp_i;
        st_nxt.cmp_s2 = st_r.cmp_s1;
        st_nxt.tl_s1  = thermal_limit_flag_i;
        st_nxt.tl_s2  = st_r.tl_s1;
        st_nxt.uv_s1  = logic_uv_i || battery_supply_uv_i;
        st_nxt.uv_s2  = st_r.uv_s1;
        st_nxt.ov_s1  = overvoltage_flag_i;
        st_nxt.ov_s2  = st_r.ov_s1;
        st_nxt.slp_s1 = sleep_i;
        st_nxt.slp_s2 = st_r.slp_s1;
        pd_now     = st_r.pd_en & {N_OUT{!st_r.slp_s2}}; // see R4
        // Only off outputs, live pull-down, filter expired
        detect     = st_r.cmp_s2 & ~st_r.out_on & pd_now & {N_OUT{expired}}; // see R1, R5, R6
        good_frame = lk.frame_done && lk.frame_ok;
        cmd        = lk.rx_word[ofs_pkg::CMD_HI:ofs_pkg::CMD_LO];
        // Only bits whose fault has gone may drop once read
        clr_mask   = {N_OUT{good_frame && st_r.msg == ofs_pkg::OFS_MSG_ONE}}
                     & ~st_r.cmp_s2; // see R15
        st_nxt.ol_lat = ((st_r.ol_lat & ~clr_mask) | detect) & pd_now; // see R7, R3
        if (st_r.rst_flag && good_frame && st_r.msg == ofs_pkg::OFS_MSG_TWO) begin
            st_nxt.rst_flag = 1'b0;
        end
        // Commands act regardless of a low but valid battery level
        if (good_frame) begin // see R10
            unique case (st_r.msg)
                ofs_pkg::OFS_MSG_ONE:  st_nxt.msg = ofs_pkg::OFS_MSG_TWO;
                ofs_pkg::OFS_MSG_TWO:  st_nxt.msg = ofs_pkg::OFS_MSG_ONE;
                ofs_pkg::OFS_MSG_THERMAL_LIMIT_FLAG: st_nxt.msg = ofs_pkg::OFS_MSG_ONE;
                default:               st_nxt.msg = ofs_pkg::OFS_MSG_ONE;
            endcase
            if (cmd == ofs_pkg::CMD_OUT_CTRL) begin
                st_nxt.out_on = lk.rx_word[N_OUT-1:0];
            end else if (cmd == ofs_pkg::CMD_PD_CTRL) begin
                st_nxt.pd_en = lk.rx_word[N_OUT-1:0]; // see R4
            end else if (cmd == ofs_pkg::CMD_THERMAL_LIMIT_FLAG_QUERY) begin
                st_nxt.msg = ofs_pkg::OFS_MSG_THERMAL_LIMIT_FLAG; // see R14
            end
        end
        if (st_r.uv_s2) begin // see R8, R9
            st_nxt.out_on   = N_OUT'(ofs_pkg::OUT_RESET);
            st_nxt.pd_en    = N_OUT'(ofs_pkg::PD_RESET);
            st_nxt.ol_lat   = '0;
            st_nxt.msg      = ofs_pkg::OFS_MSG_ONE;
            st_nxt.rst_flag = 1'b1;
        end
        st_nxt.drv    = st_r.out_on & {N_OUT{!(st_r.uv_s2 || st_r.ov_s2)}}; // see R8, R9, R11
        st_nxt.pd_eff = pd_now;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_r          <= '0;
            st_r.out_on   <= N_OUT'(ofs_pkg::OUT_RESET);
            st_r.pd_en    <= N_OUT'(ofs_pkg::PD_RESET); // see R2
            st_r.pd_eff   <= N_OUT'(ofs_pkg::PD_RESET);
            st_r.rst_flag <= 1'b1;
            st_r.msg      <= ofs_pkg::OFS_MSG_ONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Response word for the next frame
    always_comb begin
        report     = st_r.ol_lat & st_r.pd_eff; // see R3
        fault_lead = st_r.ov_s2 || (|st_r.tl_s2); // see R12
        tx_w       = '0;
        unique case (st_r.msg)
            ofs_pkg::OFS_MSG_ONE: begin
                tx_w[ofs_pkg::RSP_FAULT_BIT] = fault_lead;
                tx_w[N_OUT-1:0]              = report; // see R12
            end
            ofs_pkg::OFS_MSG_TWO: begin
                tx_w[ofs_pkg::RSP_FAULT_BIT] = fault_lead;
                tx_w[ofs_pkg::RSP_RESET_BIT] = st_r.rst_flag;
                tx_w[ofs_pkg::RSP_TRIM_BIT]  = trim_set_i; // see R13
            end
            ofs_pkg::OFS_MSG_THERMAL_LIMIT_FLAG: begin
                tx_w[ofs_pkg::THERMAL_LIMIT_FLAG_CURRENT_DRIVER_ONE_BIT]        = st_r.tl_s2[N_OUT];
                tx_w[ofs_pkg::THERMAL_LIMIT_FLAG_OSS_LO +: N_OUT] = st_r.tl_s2[N_OUT-1:0]; // see R14
            end
            default: tx_w = '0;
        endcase
    end

    assign lk.tx_word            = tx_w;
    assign octal_switch_output_o = st_r.drv;
    assign pulldown_en_o         = st_r.pd_eff;

    // Checks
    logic [N_OUT-1:0] drop_ok;
    logic             pd_cmd;
    assign drop_ok = clr_mask | ~pd_now | {N_OUT{st_r.uv_s2}};
    assign pd_cmd  = good_frame && cmd == ofs_pkg::CMD_PD_CTRL;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    property p_off_only;
        (st_r.ol_lat & ~$past(st_r.ol_lat) & $past(st_r.out_on)) == '0;
    endproperty
    a_off_only: assert property (p_off_only) else $error("open load latched while on"); // see R1

    property p_pd_power_up;
        $fell(rst_i) |-> st_r.pd_en == '1 && pulldown_en_o == '1;
    endproperty
    a_pd_power_up: assert property (p_pd_power_up) else $error("pull-down not on at reset"); // see R2

    property p_masked_zero;
        st_r.msg == ofs_pkg::OFS_MSG_ONE |-> (lk.tx_word[N_OUT-1:0] & ~pulldown_en_o) == '0;
    endproperty
    a_masked_zero: assert property (p_masked_zero) else $error("disabled output reports fault"); // see R3

    property p_pd_drop;
        (~pulldown_en_o & $past(pulldown_en_o)) != '0 |-> $past(st_r.slp_s2) || $past(pd_cmd, 2);
    endproperty
    a_pd_drop: assert property (p_pd_drop) else $error("pull-down dropped without cause"); // see R4

    property p_filter;
        (st_r.ol_lat & ~$past(st_r.ol_lat)) != '0 |-> $past(expired);
    endproperty
    a_filter: assert property (p_filter) else $error("fault latched before delay"); // see R5

    property p_latch_hold;
        (~st_r.ol_lat & $past(st_r.ol_lat) & ~$past(drop_ok)) == '0;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched fault lost unread"); // see R7

    property p_read_clear;
        good_frame && st_r.msg == ofs_pkg::OFS_MSG_ONE && st_r.cmp_s2 == '0 && !expired
            |=> st_r.ol_lat == '0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read fault not cleared"); // see R15

    property p_uv_off;
        st_r.uv_s2 |=> octal_switch_output_o == '0 && st_r.out_on == N_OUT'(ofs_pkg::OUT_RESET)
            && st_r.pd_en == N_OUT'(ofs_pkg::PD_RESET);
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("undervoltage did not reset"); // see R8, R9

    property p_ov_off;
        st_r.ov_s2 [*2] |-> octal_switch_output_o == '0;
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("overvoltage left outputs on"); // see R11

    property p_lead_bit;
        st_r.msg != ofs_pkg::OFS_MSG_THERMAL_LIMIT_FLAG && st_r.ov_s2 |-> lk.tx_word[ofs_pkg::RSP_FAULT_BIT];
    endproperty
    a_lead_bit: assert property (p_lead_bit) else $error("leading fault bit missing"); // see R12

    property p_trim;
        st_r.msg == ofs_pkg::OFS_MSG_TWO |-> lk.tx_word[ofs_pkg::RSP_TRIM_BIT] == trim_set_i;
    endproperty
    a_trim: assert property (p_trim) else $error("trim bit wrong"); // see R13

    property p_thermal_limit_flag_rsp;
        good_frame && cmd == ofs_pkg::CMD_THERMAL_LIMIT_FLAG_QUERY && !st_r.uv_s2
            |=> lk.tx_word[ofs_pkg::THERMAL_LIMIT_FLAG_CURRENT_DRIVER_ONE_BIT] == st_r.tl_s2[N_OUT]
            && lk.tx_word[ofs_pkg::THERMAL_LIMIT_FLAG_OSS_LO +: N_OUT] == st_r.tl_s2[N_OUT-1:0];
    endproperty
    a_thermal_limit_flag_rsp: assert property (p_thermal_limit_flag_rsp) else $error("thermal query answer wrong"); // see R14

    // Command effects and recovery, one cycle after the cause
    property p_thermal_limit_flag_step;
        good_frame && st_r.msg == ofs_pkg::OFS_MSG_THERMAL_LIMIT_FLAG && !st_r.uv_s2
            |=> st_r.msg == ofs_pkg::OFS_MSG_ONE;
    endproperty
    a_thermal_limit_flag_step: assert property (p_thermal_limit_flag_step) else $error("thermal word repeated"); // see R14

    property p_latch_set;
        detect != '0 && !st_r.uv_s2 |=> (st_r.ol_lat & $past(detect)) == $past(detect);
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("open load not latched"); // see R7

    property p_drv_follow;
        !st_r.uv_s2 && !st_r.ov_s2 |=> octal_switch_output_o == $past(st_r.out_on);
    endproperty
    a_drv_follow: assert property (p_drv_follow) else $error("outputs wrong"); // see R11

    property p_out_cmd;
        good_frame && cmd == ofs_pkg::CMD_OUT_CTRL && !st_r.uv_s2
            |=> st_r.out_on == $past(lk.rx_word[N_OUT-1:0]);
    endproperty
    a_out_cmd: assert property (p_out_cmd) else $error("output command lost"); // see R10

    property p_pd_cmd;
        pd_cmd && !st_r.uv_s2 |=> st_r.pd_en == $past(lk.rx_word[N_OUT-1:0]);
    endproperty
    a_pd_cmd: assert property (p_pd_cmd) else $error("pull-down command lost"); // see R4

    property p_pd_sleep;
        st_r.slp_s2 |=> pulldown_en_o == '0;
    endproperty
    a_pd_sleep: assert property (p_pd_sleep) else $error("pull-down on in sleep"); // see R4

    property p_uv_flag;
        st_r.uv_s2 |=> st_r.rst_flag && st_r.msg == ofs_pkg::OFS_MSG_ONE;
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("reset flag not set"); // see R8, R9

    property p_msg_step;
        good_frame && st_r.msg == ofs_pkg::OFS_MSG_ONE && cmd != ofs_pkg::CMD_THERMAL_LIMIT_FLAG_QUERY
            && !st_r.uv_s2 |=> st_r.msg == ofs_pkg::OFS_MSG_TWO;
    endproperty
    a_msg_step: assert property (p_msg_step) else $error("second message skipped"); // see R13

    c_open_latch: cover property ((st_r.ol_lat & ~$past(st_r.ol_lat)) != '0);
    c_thermal_limit_flag_query: cover property (good_frame && cmd == ofs_pkg::CMD_THERMAL_LIMIT_FLAG_QUERY);
    c_uv_event:   cover property ($rose(st_r.uv_s2));
    c_read_clear: cover property ((~st_r.ol_lat & $past(st_r.ol_lat)) != '0);
    c_sleep:      cover property ($rose(st_r.slp_s2));
endmodule
`default_nettype wire

// file: common/ofs_pkg.sv
// Shared constants and types for the output fault supervisor
package ofs_pkg;
    localparam int unsigned N_OUT       = 8;
    localparam int unsigned N_THERMAL_LIMIT_FLAG      = N_OUT + 1;
    localparam int unsigned WORD_BITS   = 16;
    localparam int unsigned CNT_W       = 5;
    localparam int unsigned CMD_HI      = 15;
    localparam int unsigned CMD_LO      = 11;
    localparam int unsigned CMD_W       = CMD_HI - CMD_LO + 1;
    localparam logic [4:0]  CMD_OUT_CTRL   = 5'h01;
    localparam logic [4:0]  CMD_PD_CTRL    = 5'h02;
    localparam logic [4:0]  CMD_THERMAL_LIMIT_FLAG_QUERY = 5'h1C;
    localparam int unsigned RSP_FAULT_BIT  = 15;
    localparam int unsigned RSP_RESET_BIT  = 14;
    localparam int unsigned RSP_TRIM_BIT   = 13;
    localparam int unsigned THERMAL_LIMIT_FLAG_CURRENT_DRIVER_ONE_BIT  = 9;
    localparam int unsigned THERMAL_LIMIT_FLAG_OSS_LO    = 1;
    localparam logic [7:0]  OUT_RESET      = 8'h00;
    localparam logic [7:0]  PD_RESET       = 8'hFF;
    localparam int unsigned CLK_KHZ        = 40000;
    localparam int unsigned FILTER_MIN_US  = 100;
    localparam int unsigned FILTER_MAX_US  = 450;
    localparam int unsigned FILTER_CYC     = (FILTER_MIN_US * CLK_KHZ + 999) / 1000;

    typedef enum logic [1:0] {
        OFS_MSG_ONE  = 2'h0,
        OFS_MSG_TWO  = 2'h1,
        OFS_MSG_THERMAL_LIMIT_FLAG = 2'h3
    } ofs_msg_t;
endpackage

// file: common/ofs_link_if.sv
// Word-level link between the serial shifter and the supervisor core
`timescale 1ns/100ps
`default_nettype none
interface ofs_link_if;
    logic [15:0] rx_word;
    logic [15:0] tx_word;
    logic        frame_done;
    logic        frame_ok;

    modport link (output rx_word, output frame_done, output frame_ok, input tx_word);
    modport core (input rx_word, input frame_done, input frame_ok, output tx_word);
endinterface
`default_nettype wire

// file: design/ofs_fault_timer.sv
// Open-load fault delay timer, restarted by each chip-select release
`timescale 1ns/100ps
`default_nettype none
module ofs_fault_timer #(
    parameter int unsigned DELAY_CYC = ofs_pkg::FILTER_CYC
) (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic restart_i,
    output logic      expired_o
);
    localparam int unsigned W = $clog2(DELAY_CYC + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         expired;
    } ofs_tmr_t;

    ofs_tmr_t st_r;
    ofs_tmr_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (restart_i) begin // see R6
            st_nxt.cnt     = '0;
            st_nxt.expired = 1'b0;
        end else if (!st_r.expired) begin
            st_nxt.cnt = st_r.cnt + W'(1);
            if (st_r.cnt == W'(DELAY_CYC - 1)) begin // see R5
                st_nxt.expired = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign expired_o = st_r.expired;

    // Independent age count for the checks
    logic [W:0] age_r;
    always_ff @(posedge clock_i) begin
        if (rst_i || restart_i) begin
            age_r <= '0;
        end else if (age_r != {(W+1){1'b1}}) begin
            age_r <= age_r + (W+1)'(1);
        end
    end

    property p_delay_early;
        @(posedge clock_i) disable iff (rst_i) expired_o |-> age_r >= (W+1)'(DELAY_CYC);
    endproperty
    a_delay_early: assert property (p_delay_early) else $error("timer expired early"); // see R5

    property p_delay_late;
        @(posedge clock_i) disable iff (rst_i)
            (age_r == (W+1)'(DELAY_CYC)) && !restart_i |-> expired_o;
    endproperty
    a_delay_late: assert property (p_delay_late) else $error("timer expired late"); // see R5

    property p_restart;
        @(posedge clock_i) disable iff (rst_i) restart_i |=> !expired_o;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not honoured"); // see R6
endmodule
`default_nettype wire

// file: design/ofs_spi_link.sv
// Serial shifter: samples the link pins and moves 16-bit words
`timescale 1ns/100ps
`default_nettype none
module ofs_spi_link (
    input  wire logic  clock_i,
    input  wire logic  rst_i,
    input  wire logic  sclk_i,
    input  wire logic  cs_n_i,
    input  wire logic  mosi_i,
    output logic       miso_o,
    output logic       miso_oe_n_o,
    ofs_link_if.link   lk
);
    localparam int unsigned CW = ofs_pkg::CNT_W;
    localparam int unsigned WB = ofs_pkg::WORD_BITS;

    typedef struct packed {
        logic          sck_s1, sck_s2, sck_d;
        logic          cs_s1, cs_s2, cs_d;
        logic          mi_s1, mi_s2;
        logic [WB-1:0] rx, tx, rxw;
        logic [CW-1:0] cnt;
        logic          so, sel, done, ok;
    } ofs_spi_t;

    ofs_spi_t st_r;
    ofs_spi_t st_nxt;
    logic     cs_fall, cs_rise, sck_rise, sck_fall;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.sck_s1 = sclk_i;
        st_nxt.sck_s2 = st_r.sck_s1;
        st_nxt.sck_d  = st_r.sck_s2;
        st_nxt.cs_s1  = cs_n_i;
        st_nxt.cs_s2  = st_r.cs_s1;
        st_nxt.cs_d   = st_r.cs_s2;
        st_nxt.mi_s1  = mosi_i;
        st_nxt.mi_s2  = st_r.mi_s1;
        st_nxt.done   = 1'b0;
        cs_fall  = !st_r.cs_s2 && st_r.cs_d;
        cs_rise  = st_r.cs_s2 && !st_r.cs_d;
        sck_rise = st_r.sck_s2 && !st_r.sck_d;
        sck_fall = !st_r.sck_s2 && st_r.sck_d;
        if (cs_fall) begin
            st_nxt.tx  = lk.tx_word;
            st_nxt.so  = lk.tx_word[WB-1];
            st_nxt.rx  = '0;
            st_nxt.cnt = '0;
            st_nxt.sel = 1'b1;
        end else if (st_r.sel && sck_rise) begin
            st_nxt.rx = {st_r.rx[WB-2:0], st_r.mi_s2};
            // Saturates so an overlong frame never wraps to a valid count
            if (st_r.cnt != {CW{1'b1}}) begin
                st_nxt.cnt = st_r.cnt + CW'(1);
            end
        end else if (st_r.sel && sck_fall) begin
            st_nxt.tx = {st_r.tx[WB-2:0], 1'b0};
            st_nxt.so = st_r.tx[WB-2];
        end
        if (cs_rise && st_r.sel) begin
            st_nxt.sel  = 1'b0;
            st_nxt.done = 1'b1;
            st_nxt.ok   = (st_r.cnt == CW'(WB));
            st_nxt.rxw  = st_r.rx;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_r       <= '0;
            st_r.sck_s1 <= 1'b0;
            st_r.cs_s1 <= 1'b1;
            st_r.cs_s2 <= 1'b1;
            st_r.cs_d  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign miso_o        = st_r.so;
    assign miso_oe_n_o   = !st_r.sel;
    assign lk.rx_word    = st_r.rxw;
    assign lk.frame_done = st_r.done;
    assign lk.frame_ok   = st_r.ok;
endmodule
`default_nettype wire

// file: design/ofs_spi_link_unused.sv
// Holds no logic of its own; the serial shifter is ofs_spi_link

// file: dv/ofs_host_model.sv
// Host-side serial master model that moves whole 16-bit words
`timescale 1ns/100ps
`default_nettype none
module ofs_host_model (
    input  wire logic clock_i,
    input  wire logic miso_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Half period of 4 clocks gives the 200 ns serial clock
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clock_i);
        cs_n_o = 1'b0;
        repeat (8) @(negedge clock_i);
        for (int i = 0; i < 16; i++) begin
            mosi_o = tx[15 - i];
            repeat (4) @(negedge clock_i);
            sclk_o = 1'b1;
            rx = {rx[14:0], miso_i};
            repeat (4) @(negedge clock_i);
            sclk_o = 1'b0;
        end
        repeat (4) @(negedge clock_i);
        cs_n_o = 1'b1;
        // Released data line must not keep showing the last bit
        mosi_o = ~mosi_o;
        // Long enough for frame capture and output update after deselect
        repeat (12) @(negedge clock_i);
    endtask
endmodule
`default_nettype wire

// file: dv/output_fault_supervisor_bench.sv
// Self-checking bench for the output fault supervisor
`timescale 1ns/100ps
`default_nettype none
module output_fault_supervisor_bench;
    // Short fault delay keeps the run small; expectations scale with it
    localparam int unsigned DELAY = 400;
    logic       clock, rst, sclk, cs_n, mosi, miso, miso_oe_n;
    logic       miso_last = 1'b0;
    wire logic  miso_line;
    logic [7:0] open_cmp, outs, pd_en;
    logic [8:0] thermal_flag;
    logic       logic_uv, bat_uv, over_v, sleep, trim;
    int         n_fail = 0;
    int         cmp_count = 0;

    ofs_supervisor #(.DELAY_CYC(DELAY)) u_ofs_supervisor (
        .clock_i(clock), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
        .miso_o(miso), .miso_oe_n_o(miso_oe_n), .open_cmp_i(open_cmp),
        .thermal_limit_flag_i(thermal_flag), .logic_uv_i(logic_uv),
        .battery_supply_uv_i(bat_uv), .overvoltage_flag_i(over_v), .sleep_i(sleep),
        .trim_set_i(trim), .octal_switch_output_o(outs), .pulldown_en_o(pd_en));
    ofs_host_model u_ofs_host_model (
        .clock_i(clock), .miso_i(miso_line), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

    // Undriven data line shows the inverse of its last bit, not a settled guess
    always @(posedge clock) begin
        if (!miso_oe_n) begin
            miso_last <= miso;
        end
    end
    assign miso_line = miso_oe_n ? ~miso_last : miso;

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic stop_test();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic fx(input logic [15:0] cmd, input logic [15:0] expv);
        logic [15:0] rx;
        u_ofs_host_model.xfer(cmd, rx);
        check(rx, expv);
    endtask

    task automatic s_reset();
        check({8'h00, outs}, 16'h0000);
        check({8'h00, pd_en}, 16'h00FF);
        check({15'h0000, miso_oe_n}, 16'h0001);
    endtask

    task automatic s_msgs();
        trim = 1'b1;
        // Data line must be driven while selected
        fork
            fx(16'h0000, 16'h0000);
            begin
                cyc(20);
                check({15'h0000, miso_oe_n}, 16'h0000);
            end
        join
        fx(16'h0000, 16'h6000);
        fx(16'h0000, 16'h0000);
        trim = 1'b0;
        fx(16'h0000, 16'h0000);
        fx({ofs_pkg::CMD_OUT_CTRL, 3'h0, 8'hA5}, 16'h0000);
        check({8'h00, outs}, 16'h00A5);
        trim = 1'b1;
    endtask

    // Only outputs commanded off (5A) may latch an open load
    task automatic s_open();
        open_cmp = 8'hFF;
        // Two frames must both end before the delay runs out
        cyc(100);
        fx(16'h0000, 16'h2000);
        fx(16'h0000, 16'h0000);
        cyc(DELAY + 100);
        fx(16'h0000, 16'h2000);
        fx(16'h0000, 16'h005A);
        open_cmp = 8'h00;
        fx(16'h0000, 16'h2000);
        fx(16'h0000, 16'h005A);
        fx(16'h0000, 16'h2000);
        fx(16'h0000, 16'h0000);
    endtask

    task automatic s_pulldown();
        fx({ofs_pkg::CMD_PD_CTRL, 3'h0, 8'h0F}, 16'h2000);
        check({8'h00, pd_en}, 16'h000F);
        open_cmp = 8'hFF;
        cyc(DELAY + 100);
        open_cmp = 8'h00;
        fx(16'h0000, 16'h000A);
        sleep = 1'b1;
        cyc(8);
        check({8'h00, pd_en}, 16'h0000);
        sleep = 1'b0;
        cyc(8);
        check({8'h00, pd_en}, 16'h000F);
    endtask

    task automatic s_thermal_ov();
        thermal_flag = 9'h1A5;
        cyc(4);
        fx({ofs_pkg::CMD_THERMAL_LIMIT_FLAG_QUERY, 11'h000}, 16'hA000);
        fx(16'h0000, 16'h034A);
        fx(16'h0000, 16'h8000);
        thermal_flag = 9'h000;
        over_v = 1'b1;
        cyc(8);
        check({8'h00, outs}, 16'h0000);
        fx(16'h0000, 16'hA000);
        over_v = 1'b0;
        cyc(8);
        check({8'h00, outs}, 16'h00A5);
    endtask

    // Undervoltage restarts the message order at message one; both words are pooled for the reset bit
    task automatic s_uv();
        logic [15:0] rx_p;
        logic [15:0] rx_q;
        for (int k = 0; k < 2; k++) begin
            u_ofs_host_model.xfer({ofs_pkg::CMD_OUT_CTRL, 3'h0, 8'h3C}, rx_p);
            check({8'h00, outs}, 16'h003C);
            logic_uv = (k == 0);
            bat_uv = (k == 1);
            cyc(8);
            check({8'h00, outs}, 16'h0000);
            check({8'h00, pd_en}, 16'h00FF);
            logic_uv = 1'b0;
            bat_uv = 1'b0;
            cyc(8);
            check({8'h00, outs}, 16'h0000);
            u_ofs_host_model.xfer(16'h0000, rx_p);
            u_ofs_host_model.xfer(16'h0000, rx_q);
            check((rx_p | rx_q) & 16'h4000, 16'h4000);
        end
    endtask

    initial begin
        rst = 1'b1;
        open_cmp = 8'h00;
        thermal_flag = 9'h000;
        logic_uv = 1'b0;
        bat_uv = 1'b0;
        over_v = 1'b0;
        sleep = 1'b0;
        trim = 1'b0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        cyc(4);
        s_reset();
        s_msgs();
        s_open();
        s_pulldown();
        s_thermal_ov();
        s_uv();
        stop_test();
    end

    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
